// [design/bcc_pkg.sv]
// Package with register map, field layout and helpers for the bus common control block.
package bcc_pkg;
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam int POS_IDLE_CODE    = 6;
  localparam int POS_METHOD       = 5;
  localparam int POS_RSVD_ONE     = 4;
  localparam int POS_RSVD_ZERO    = 3;
  localparam int POS_AUX_DRIVE    = 2;
  localparam int POS_MEM_DRIVE    = 1;
  localparam int POS_STROBE_DRIVE = 0;
  localparam int POS_ST_BUSY      = 0;
  localparam int POS_ST_LAST_DMA_ACKNOWLEDGE_STROBE = 1;
  localparam int POS_ST_REMAIN    = 4;
  localparam logic [2:0] CLK_MODE_SEL_A = 3'h2;
  localparam logic [2:0] CLK_MODE_SEL_B = 3'h6;
  localparam logic [2:0] CLK_MODE_INPUT = 3'h7;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE  = 4'h1;

  typedef struct packed {
    logic [2:0] dma_idle_cycle_count;
    logic       dma_idle_insert_method;
    logic       aux_clock_pin_drive;
    logic       standby_memory_pin_float;
    logic       standby_release_strobe_float;
  } bcc_ctrl_t;

  localparam bcc_ctrl_t CTRL_RESET = '{3'h0, 1'b0, 1'b0, 1'b0, 1'b0};

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_GAP,
    ST_BUSY
  } bcc_state_t;

  function automatic logic [3:0] idle_cycles(input logic [2:0] code);
    logic [3:0] n;
    n = 4'h0;
    unique case (code)
      3'h0: n = 4'h0;
      3'h1: n = 4'h1;
      3'h2: n = 4'h2;
      3'h3: n = 4'h4;
      3'h4: n = 4'h6;
      3'h5: n = 4'h8;
      3'h6: n = 4'hA;
      3'h7: n = 4'hC;
    endcase
    return n;
  endfunction : idle_cycles

  function automatic logic [31:0] ctrl_word(input bcc_ctrl_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[POS_IDLE_CODE +: 3]  = c.dma_idle_cycle_count;
    w[POS_METHOD]          = c.dma_idle_insert_method;
    w[POS_RSVD_ONE]        = 1'b1;
    w[POS_RSVD_ZERO]       = 1'b0;
    w[POS_AUX_DRIVE]       = c.aux_clock_pin_drive;
    w[POS_MEM_DRIVE]       = c.standby_memory_pin_float;
    w[POS_STROBE_DRIVE]    = c.standby_release_strobe_float;
    return w;
  endfunction : ctrl_word
endpackage : bcc_pkg

// [design/bcc_top.sv]
// Bus common control low bits: APB register, DMA idle-cycle insertion and pin drive control.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module bcc_top (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [2:0]  CLOCK_MODE,
  input  wire logic        SOFTWARE_STANDBY,
  input  wire logic        BUS_RELEASED,
  input  wire logic        ACC_REQ,
  input  wire logic        ACC_DMA_ACKNOWLEDGE_STROBE,
  input  wire logic        ACC_DONE,
  output logic             ACC_GRANT,
  output logic             AUX_BUS_CLOCK_PIN_O,
  output logic             AUX_BUS_CLOCK_PIN_OE,
  output logic             MEMORY_PINS_OE,
  output logic             STROBE_PINS_OE
);

  bcc_pkg::bcc_ctrl_t  ctrl_q;
  bcc_pkg::bcc_ctrl_t  ctrl_d;
  logic [31:0]         prdata_q;
  logic [31:0]         prdata_d;
  logic                pslverr_q;
  logic                pslverr_d;
  bcc_pkg::bcc_state_t st_q;
  bcc_pkg::bcc_state_t st_d;
  logic [3:0]          cnt_q;
  logic [3:0]          cnt_d;
  logic                last_dma_acknowledge_strobe_q;
  logic                last_dma_acknowledge_strobe_d;
  logic                cur_dma_acknowledge_strobe_q;
  logic                cur_dma_acknowledge_strobe_d;
  logic                aux_en_q;
  logic                aux_en_d;
  logic                mem_oe_q;
  logic                mem_oe_d;
  logic                strobe_oe_q;
  logic                strobe_oe_d;
  logic                aux_oe_q;
  logic                aux_oe_d;
  logic                setup;
  logic                hit_ctrl;
  logic                hit_status;
  logic                need_gap;
  logic [3:0]          gap_cycles;
  logic [31:0]         status_word;
  logic                acc_phase;
  logic                bad_target;
  logic                float_strobe_req;
  logic                float_mem_req;
  logic                mode_input;
  logic                mode_selects;

  // A pin group stays driven unless a low-power state asks it to float and its keep bit is clear.
  function automatic logic keep_driven(input logic float_req, input logic keep_bit);
    logic drive;
    drive = keep_bit || !float_req;
    return drive;
  endfunction : keep_driven

  // Only two clock modes let software choose between a low level and the clock on the auxiliary pin.
  function automatic logic honours_drive_bit(input logic [2:0] mode);
    logic hit;
    hit = (mode == bcc_pkg::CLK_MODE_SEL_A) || (mode == bcc_pkg::CLK_MODE_SEL_B);
    return hit;
  endfunction : honours_drive_bit

  // Reserved bits are not stored, so a wrong write value cannot disturb them.
  function automatic bcc_pkg::bcc_ctrl_t ctrl_from_word(input logic [31:0] w);
    bcc_pkg::bcc_ctrl_t c;
    c.dma_idle_cycle_count         = w[bcc_pkg::POS_IDLE_CODE +: 3];
    c.dma_idle_insert_method       = w[bcc_pkg::POS_METHOD];
    c.aux_clock_pin_drive          = w[bcc_pkg::POS_AUX_DRIVE];
    c.standby_memory_pin_float     = w[bcc_pkg::POS_MEM_DRIVE];
    c.standby_release_strobe_float = w[bcc_pkg::POS_STROBE_DRIVE];
    return c;
  endfunction : ctrl_from_word

  always_comb begin
    setup      = PSEL && !PENABLE;
    acc_phase  = PSEL && PENABLE;
    hit_ctrl   = (PADDR == bcc_pkg::OFF_CTRL);
    hit_status = (PADDR == bcc_pkg::OFF_STATUS);
    bad_target = !(hit_ctrl || (hit_status && !PWRITE));
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[bcc_pkg::POS_ST_BUSY]        = (st_q != bcc_pkg::ST_IDLE);
    status_word[bcc_pkg::POS_ST_LAST_DMA_ACKNOWLEDGE_STROBE]   = last_dma_acknowledge_strobe_q;
    status_word[bcc_pkg::POS_ST_REMAIN +: 4] = cnt_q;
  end

  // The register answers without wait states; read data is captured in the setup cycle.
  always_comb begin
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (setup) begin
      pslverr_d = bad_target;
      if (hit_ctrl) begin
        prdata_d = bcc_pkg::ctrl_word(ctrl_q);
      end else if (hit_status) begin
        prdata_d = status_word;
      end else begin
        prdata_d = 32'h0000_0000;
      end
    end
  end

  // A write lands only at the end of the access phase, so an aborted setup leaves the register alone.
  always_comb begin
    ctrl_d = ctrl_q;
    if (acc_phase && PWRITE && hit_ctrl) begin
      ctrl_d = ctrl_from_word(PWDATA);
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= bcc_pkg::CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign PRDATA  = prdata_q;
  assign PREADY  = 1'b1;
  assign PSLVERR = acc_phase && pslverr_q;

  // Idle insertion is decided when the next access asks, since only then is its driver known.
  always_comb begin
    gap_cycles = bcc_pkg::idle_cycles(ctrl_q.dma_idle_cycle_count);
    if (ctrl_q.dma_idle_insert_method) begin
      need_gap = last_dma_acknowledge_strobe_q;
    end else begin
      need_gap = last_dma_acknowledge_strobe_q && !ACC_DMA_ACKNOWLEDGE_STROBE;
    end
  end

  always_comb begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    last_dma_acknowledge_strobe_d = last_dma_acknowledge_strobe_q;
    cur_dma_acknowledge_strobe_d  = cur_dma_acknowledge_strobe_q;
    ACC_GRANT   = 1'b0;
    unique case (st_q)
      bcc_pkg::ST_IDLE: begin
        if (ACC_REQ) begin
          if (need_gap && (gap_cycles != bcc_pkg::CNT_ZERO)) begin
            st_d  = bcc_pkg::ST_GAP;
            cnt_d = gap_cycles;
          end else begin
            ACC_GRANT  = 1'b1;
            cur_dma_acknowledge_strobe_d = ACC_DMA_ACKNOWLEDGE_STROBE;
            st_d       = bcc_pkg::ST_BUSY;
          end
        end
      end
      bcc_pkg::ST_GAP: begin
        cnt_d = cnt_q - bcc_pkg::CNT_ONE;
        if (cnt_q == bcc_pkg::CNT_ONE) begin
          ACC_GRANT  = 1'b1;
          cur_dma_acknowledge_strobe_d = ACC_DMA_ACKNOWLEDGE_STROBE;
          st_d       = bcc_pkg::ST_BUSY;
        end
      end
      bcc_pkg::ST_BUSY: begin
        if (ACC_DONE) begin
          last_dma_acknowledge_strobe_d = cur_dma_acknowledge_strobe_q;
          st_d        = bcc_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= bcc_pkg::ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // The gap counter keeps its own register so the remaining count can be read back at any time.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_q <= bcc_pkg::CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      last_dma_acknowledge_strobe_q <= 1'b0;
      cur_dma_acknowledge_strobe_q  <= 1'b0;
    end else begin
      last_dma_acknowledge_strobe_q <= last_dma_acknowledge_strobe_d;
      cur_dma_acknowledge_strobe_q  <= cur_dma_acknowledge_strobe_d;
    end
  end

  always_comb begin
    float_strobe_req = SOFTWARE_STANDBY || BUS_RELEASED;
    float_mem_req    = SOFTWARE_STANDBY;
    mode_input       = (CLOCK_MODE == bcc_pkg::CLK_MODE_INPUT);
    mode_selects     = honours_drive_bit(CLOCK_MODE);
  end

  // Pin enables are registered, so they follow a control write or a mode change by one clock.
  always_comb begin
    if (mode_input) begin
      aux_oe_d = 1'b0;
      aux_en_d = 1'b0;
    end else begin
      aux_oe_d = keep_driven(float_strobe_req, ctrl_q.standby_release_strobe_float);
      if (mode_selects) begin
        aux_en_d = ctrl_q.aux_clock_pin_drive;
      end else begin
        aux_en_d = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aux_en_q <= 1'b0;
      aux_oe_q <= 1'b0;
    end else begin
      aux_en_q <= aux_en_d;
      aux_oe_q <= aux_oe_d;
    end
  end

  always_comb begin
    strobe_oe_d = keep_driven(float_strobe_req, ctrl_q.standby_release_strobe_float);
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      strobe_oe_q <= 1'b0;
    end else begin
      strobe_oe_q <= strobe_oe_d;
    end
  end

  // Memory pins only float in standby; a bus release leaves them to the new owner's timing.
  always_comb begin
    mem_oe_d = keep_driven(float_mem_req, ctrl_q.standby_memory_pin_float);
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mem_oe_q <= 1'b0;
    end else begin
      mem_oe_q <= mem_oe_d;
    end
  end

  // The forwarded clock is gated by a registered enable; a real chip would use a clock gate cell here.
  assign AUX_BUS_CLOCK_PIN_O  = aux_en_q && CLK;
  assign AUX_BUS_CLOCK_PIN_OE = aux_oe_q;
  assign MEMORY_PINS_OE       = mem_oe_q;
  assign STROBE_PINS_OE       = strobe_oe_q;

endmodule : bcc_top
`default_nettype wire

// [verification/bcc_checker_assertions.sv]
// Concurrent checks on the ports of the bus common control block.
`timescale 1ns/1ns
`default_nettype none
module bcc_checker (
  input wire logic        CLK,
  input wire logic        ARST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic [2:0]  CLOCK_MODE,
  input wire logic        SOFTWARE_STANDBY,
  input wire logic        BUS_RELEASED,
  input wire logic        ACC_DONE,
  input wire logic        ACC_GRANT,
  input wire logic        AUX_BUS_CLOCK_PIN_OE,
  input wire logic        MEMORY_PINS_OE,
  input wire logic        STROBE_PINS_OE
);
  logic busy_q;
  logic busy_d;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  always_comb busy_d = ACC_GRANT | (busy_q & !ACC_DONE);
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) busy_q <= 1'b0;
    else busy_q <= busy_d;
  end
  a_reserved_read: assert property (PSEL && PENABLE && !PWRITE && PADDR == 12'h000
    |-> PRDATA[4] && !PRDATA[3]) else $error("reserved bits read wrong");
  a_mode7_float: assert property (CLOCK_MODE == 3'h7 |=> !AUX_BUS_CLOCK_PIN_OE)
    else $error("aux clock pin driven in mode 7");
  a_aux_driven: assert property (CLOCK_MODE != 3'h7 && !SOFTWARE_STANDBY && !BUS_RELEASED
    |=> AUX_BUS_CLOCK_PIN_OE) else $error("aux clock pin not driven");
  a_mem_driven: assert property (!SOFTWARE_STANDBY |=> MEMORY_PINS_OE)
    else $error("memory pins floated outside standby");
  a_strobe_driven: assert property (!SOFTWARE_STANDBY && !BUS_RELEASED |=> STROBE_PINS_OE)
    else $error("strobe pins floated while running");
  a_strobe_aux_pair: assert property (CLOCK_MODE != 3'h7
    |=> AUX_BUS_CLOCK_PIN_OE == STROBE_PINS_OE) else $error("aux and strobe enables differ");
  a_grant_pulse: assert property (ACC_GRANT |=> !ACC_GRANT)
    else $error("grant longer than one cycle");
  a_no_grant_busy: assert property (busy_q |-> !ACC_GRANT)
    else $error("grant while a cycle runs");
endmodule : bcc_checker
bind bcc_top bcc_checker u_chk (.CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .CLOCK_MODE,
  .SOFTWARE_STANDBY, .BUS_RELEASED, .ACC_DONE, .ACC_GRANT, .AUX_BUS_CLOCK_PIN_OE, .MEMORY_PINS_OE,
  .STROBE_PINS_OE);
`default_nettype wire

// [verification/bcc_partner.sv]
// Far-side bus model that ends each granted cycle after a chosen latency.
`timescale 1ns/1ns
`default_nettype none
module bcc_partner (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       grant,
  input  wire logic [1:0] lat,
  output logic            done
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic       done_d;
  // The top bit marks a cycle in flight, so a slow device stalls up to three more clocks.
  always_comb begin
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (grant) cnt_d = {1'b1, lat};
    else if (cnt_q == 3'h4) begin
      cnt_d = 3'h0;
      done_d = 1'b1;
    end
    else if (cnt_q[2]) cnt_d = cnt_q - 3'h1;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 3'h0;
      done <= 1'b0;
    end
    else begin
      cnt_q <= cnt_d;
      done <= done_d;
    end
  end
endmodule : bcc_partner
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking testbench for the bus common control block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk = 0, arst_n = 0, psel = 0, pen = 0, pwr = 0, sby = 0, rel = 0, req = 0, dma_acknowledge_strobe = 0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wd = 32'h0, rd, prdata;
  logic [2:0]  mode = 3'h0;
  logic [1:0]  lat = 2'h0;
  logic [7:0]  b;
  logic        pready, perr, err, grant, done, aux_o, aux_oe, mem_oe, str_oe;
  int          bad_count = 0, checked = 0, n;
  always #5 clk = ~clk;
  bcc_top u_dut (.CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(addr),
    .PWDATA(wd), .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr), .CLOCK_MODE(mode), .SOFTWARE_STANDBY(sby),
    .BUS_RELEASED(rel), .ACC_REQ(req), .ACC_DMA_ACKNOWLEDGE_STROBE(dma_acknowledge_strobe), .ACC_DONE(done), .ACC_GRANT(grant),
    .AUX_BUS_CLOCK_PIN_O(aux_o), .AUX_BUS_CLOCK_PIN_OE(aux_oe), .MEMORY_PINS_OE(mem_oe), .STROBE_PINS_OE(str_oe));
  bcc_partner u_far (.clk(clk), .arst_n(arst_n), .grant(grant), .lat(lat), .done(done));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic access(input logic d, output int cyc);
    req <= 1'b1;
    dma_acknowledge_strobe <= d;
    lat <= 2'($urandom);
    cyc = 0;
    @(negedge clk);
    while (grant !== 1'b1 && cyc < 40) begin
      @(negedge clk);
      cyc++;
    end
    @(posedge clk);
    req <= 1'b0;
    do @(posedge clk); while (done !== 1'b1);
  endtask : access
  function automatic int gap(input logic [2:0] c, input logic m, input logic d2);
    int t[8] = '{0, 1, 2, 4, 6, 8, 10, 12};
    return (m || !d2) ? t[c] : 0;
  endfunction : gap
  task automatic give_verdict;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  initial begin
    #300000;
    bad_count++;
    give_verdict();
  end
  initial begin
    n = $urandom(12);
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, 12'h000, 32'h0);
    check("ctrl reset", rd, 32'h0000_0010);
    apb(1'b0, 12'h00C, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("pready", {31'h0, pready}, 32'h1);
    for (int i = 0; i < 32; i++) begin
      b = 8'($urandom);
      // Software keeps bit 4 at one and bit 3 at zero.
      apb(1'b1, 12'h000, {23'h0, i[2:0], i[3], 2'h2, b[2:0]});
      apb(1'b0, 12'h000, 32'h0);
      check("ctrl readback", rd, {23'h0, i[2:0], i[3], 2'h2, b[2:0]});
      access(1'b1, n);
      access(i[4], n);
      check("idle gap", n, gap(i[2:0], i[3], i[4]));
    end
    apb(1'b0, 12'h004, 32'h0);
    check("status idle", rd, 32'h0000_0002);
    apb(1'b1, 12'h004, 32'h0);
    check("status write error", {31'h0, err}, 32'h1);
    for (int j = 0; j < 48; j++) begin
      b = 8'($urandom);
      apb(1'b1, 12'h000, {26'h0, 3'h2, b[2:0]});
      mode <= b[5:3];
      sby <= b[6];
      rel <= b[7];
      repeat (2) @(posedge clk);
      #1;
      check("aux oe", aux_oe, b[5:3] != 3'h7 && (b[0] || !(b[6] || b[7])));
      check("mem oe", mem_oe, b[1] || !b[6]);
      check("strobe oe", str_oe, b[0] || !(b[6] || b[7]));
      if (b[5:3] != 3'h7 && aux_oe === 1'b1)
        check("aux level", aux_o, (b[4:3] == 2'h2) ? b[2] : 1'b1);
      @(posedge clk);
    end
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
